//--- design/sync_serial_port.v
// Synchronous serial port: network receive and on-demand transmit and receive.
`include "sync_serial_defines.vh"
`default_nettype none
module sync_serial_port (
  // Core clock and reset.
  input wire CORE_CLK,
  input wire RESET,
  // Processor register port.
  input wire [15:0] ADDR,
  input wire WR_EN,
  input wire RD_EN,
  input wire [23:0] WR_DATA,
  output reg [23:0] RD_DATA,
  // Interrupt requests.
  output reg RX_INT_REQ,
  output reg TX_INT_REQ,
  // Serial inputs.
  input wire BIT_CLK_IN,
  input wire CTL_PIN0_IN,
  input wire FRAME_SYNC_IN,
  input wire SERIAL_RX_PIN,
  // Serial outputs.
  output reg BIT_CLK_OUT,
  output reg FRAME_SYNC_OUT,
  output wire SERIAL_TX_OUT,
  output reg SERIAL_TX_OE_N
);
  localparam T_IDLE = 2'h0;
  localparam T_SHIFT = 2'h1;
  localparam T_GAP = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 bit clock, 1 pin0 clock, 2 frame sync, 3 data.
  wire [3:0] pin_lvl;
  wire [3:0] pin_rise;
  wire [3:0] pin_fall;
  pin_sync u_pin_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .pins({SERIAL_RX_PIN, FRAME_SYNC_IN, CTL_PIN0_IN, BIT_CLK_IN}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  reg [23:0] ctrl_a_q;
  reg [23:0] ctrl_b_q;
  reg [23:0] tx_data_q;
  reg [23:0] tx_last_q;
  reg [23:0] tx_sh_q;
  reg [23:0] rx_sh_q;
  reg [23:0] rx_data_q;
  reg full_q;
  reg ovr_q;
  reg tde_q;
  reg tue_q;
  reg skip_q;
  reg stat_seen_q;
  reg [7:0] div_q;
  reg bclk_q;
  reg [1:0] tx_state_q;
  reg [4:0] tx_bit_q;
  reg [4:0] slot_q;
  reg [1:0] gap_q;
  reg tx_on_q;
  reg fs_q;
  reg rx_on_q;
  reg [4:0] rx_bit_q;
  reg re_q;
  reg rearm_q;
  reg [4:0] wlen_m1;

  // Control field views.
  wire [7:0] prescale = ctrl_a_q[`CA_PM_HI:`CA_PM_LO];
  wire [4:0] frame_div = ctrl_a_q[`CA_DC_HI:`CA_DC_LO];
  wire [1:0] word_len_sel = ctrl_a_q[`CA_WL_HI:`CA_WL_LO];
  wire receive_int_enable = ctrl_b_q[`CB_RIE];
  wire transmit_int_enable = ctrl_b_q[`CB_TIE];
  wire receive_enable = ctrl_b_q[`CB_RE];
  wire transmit_enable = ctrl_b_q[`CB_TE];
  wire network_mode_sel = ctrl_b_q[`CB_MOD];
  wire gated_clock_sel = ctrl_b_q[`CB_GCK];
  wire sync_clocking_sel = ctrl_b_q[`CB_SYN];
  wire bit_clock_dir = ctrl_b_q[`CB_BIT_CLOCK_DIR];

  // A zero frame divide in network mode turns the port data driven.
  wire on_demand = network_mode_sel && (frame_div == 5'h00);
  wire gated_od = on_demand && gated_clock_sel;

  // Word length decode; received words are left justified to bit 23.
  always @* begin
    case (word_len_sel)
      2'h0: wlen_m1 = `WLEN_8;
      2'h1: wlen_m1 = `WLEN_12;
      2'h2: wlen_m1 = `WLEN_16;
      default: wlen_m1 = `WLEN_24;
    endcase
  end

  // Processor port decode.
  wire wr_ctrl_a = WR_EN && (ADDR == `ADDR_CTRL_A);
  wire wr_ctrl_b = WR_EN && (ADDR == `ADDR_CTRL_B);
  wire wr_skip = WR_EN && (ADDR == `ADDR_STATUS);
  wire wr_tx = WR_EN && (ADDR == `ADDR_DATA);
  wire rd_stat = RD_EN && (ADDR == `ADDR_STATUS);
  wire rd_rx = RD_EN && (ADDR == `ADDR_DATA);
  wire [23:0] status_word = {16'h0000, full_q, tde_q, ovr_q, tue_q, 4'h0};

  ////////////////////////////////////////////////////////////////////////////////
  // Internal bit clock: toggles every prescale plus one core cycles, always running.
  wire div_end = (div_q == prescale);
  wire int_rise = div_end && !bclk_q;
  wire int_fall = div_end && bclk_q;

  // Network slot timing seen at a rising tick.
  wire slot_end = (tx_bit_q == wlen_m1);
  wire frame_start = slot_end && (slot_q == frame_div);
  wire tx_active_next = frame_start ? transmit_enable : (tx_on_q && transmit_enable);
  wire od_ready = (tx_state_q == T_IDLE) || ((tx_state_q == T_GAP) && (gap_q == `GAP_BITS));

  // Receive clock and frame sync selection; non-gated on-demand receive sync comes from the pin, gated starts on the first edge.
  wire use_int_clk = sync_clocking_sel && bit_clock_dir;
  wire ext_fall = sync_clocking_sel ? pin_fall[0] : pin_fall[1];
  wire rx_edge = use_int_clk ? int_fall : ext_fall;
  wire rx_fs = gated_od ? !rx_on_q :
               ((sync_clocking_sel && !on_demand) ? fs_q : pin_lvl[2]);
  wire [23:0] rx_next = {rx_sh_q[22:0], pin_lvl[3]};
  wire [23:0] rx_word = rx_next << (5'h17 - wlen_m1);
  wire rx_slot_done = rx_on_q && !(rx_fs && !gated_od) && (rx_bit_q == wlen_m1);

  assign SERIAL_TX_OUT = tx_sh_q[23];

  ////////////////////////////////////////////////////////////////////////////////
  // One process owns every flag so that event sets, written last, win over clears.
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_a_q <= `CTRL_RESET;
      ctrl_b_q <= `CTRL_RESET;
      tx_data_q <= 24'h000000;
      tx_last_q <= 24'h000000;
      tx_sh_q <= 24'h000000;
      rx_sh_q <= 24'h000000;
      rx_data_q <= 24'h000000;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
      tde_q <= 1'b1;
      tue_q <= 1'b0;
      skip_q <= 1'b0;
      stat_seen_q <= 1'b0;
      div_q <= 8'h00;
      bclk_q <= 1'b0;
      tx_state_q <= T_IDLE;
      tx_bit_q <= 5'h00;
      slot_q <= 5'h00;
      gap_q <= 2'h0;
      tx_on_q <= 1'b0;
      fs_q <= 1'b0;
      rx_on_q <= 1'b0;
      rx_bit_q <= 5'h00;
      re_q <= 1'b0;
      rearm_q <= 1'b0;
      RD_DATA <= 24'h000000;
      RX_INT_REQ <= 1'b0;
      TX_INT_REQ <= 1'b0;
      BIT_CLK_OUT <= 1'b0;
      FRAME_SYNC_OUT <= 1'b0;
      SERIAL_TX_OE_N <= 1'b1;
    end else begin
      // Processor writes and reads; clears come first.
      if (wr_ctrl_a) begin
        ctrl_a_q <= WR_DATA;
      end
      if (wr_ctrl_b) begin
        ctrl_b_q <= WR_DATA;
      end
      if (wr_tx) begin
        tx_data_q <= WR_DATA;
        tde_q <= 1'b0;
        skip_q <= 1'b0;
        if (stat_seen_q) begin
          tue_q <= 1'b0;
        end
      end
      if (wr_skip) begin
        tde_q <= 1'b0;
        skip_q <= 1'b1;
      end
      if (rd_stat) begin
        stat_seen_q <= 1'b1;
      end else if (rd_rx || wr_tx) begin
        stat_seen_q <= 1'b0;
      end
      if (rd_rx) begin
        full_q <= 1'b0;
        if (stat_seen_q) begin
          ovr_q <= 1'b0;
        end
      end
      if (RD_EN) begin
        case (ADDR)
          `ADDR_CTRL_A: RD_DATA <= ctrl_a_q;
          `ADDR_CTRL_B: RD_DATA <= ctrl_b_q;
          `ADDR_STATUS: RD_DATA <= status_word;
          `ADDR_DATA: RD_DATA <= rx_data_q;
          default: RD_DATA <= 24'h000000;
        endcase
      end

      // Bit clock divider ignores the enables, as do the slot counters below.
      if (div_end) begin
        div_q <= 8'h00;
        bclk_q <= ~bclk_q;
      end else begin
        div_q <= div_q + 8'h01;
      end

      // Transmit side, stepping on rising ticks of the internal clock.
      if (int_rise) begin
        fs_q <= 1'b0;
        if (!on_demand) begin
          // Periodic slots: frame sync and counters run even when disabled.
          tx_sh_q <= {tx_sh_q[22:0], 1'b0};
          if (slot_end) begin
            tx_bit_q <= 5'h00;
            slot_q <= frame_start ? 5'h00 : slot_q + 5'h01;
            fs_q <= frame_start;
            tx_on_q <= tx_active_next;
            if (!tx_active_next) begin
              SERIAL_TX_OE_N <= 1'b1;
            end else if (skip_q) begin
              skip_q <= 1'b0;
              tde_q <= 1'b1;
              SERIAL_TX_OE_N <= 1'b1;
            end else if (!tde_q) begin
              tx_sh_q <= tx_data_q;
              tx_last_q <= tx_data_q;
              tde_q <= 1'b1;
              SERIAL_TX_OE_N <= 1'b0;
            end else begin
              // Nothing supplied: repeat the previous word and flag it.
              tx_sh_q <= tx_last_q;
              tue_q <= 1'b1;
              SERIAL_TX_OE_N <= 1'b0;
            end
          end else begin
            tx_bit_q <= tx_bit_q + 5'h01;
          end
        end else begin
          // Data driven: no slots, no underrun, sync only with a word.
          if (od_ready && transmit_enable && !tde_q) begin
            tx_sh_q <= tx_data_q;
            tx_last_q <= tx_data_q;
            tde_q <= 1'b1;
            fs_q <= 1'b1;
            tx_bit_q <= 5'h00;
            tx_state_q <= T_SHIFT;
            SERIAL_TX_OE_N <= 1'b0;
          end else begin
            case (tx_state_q)
              T_IDLE: begin
                tx_bit_q <= 5'h00;
              end
              T_SHIFT: begin
                tx_sh_q <= {tx_sh_q[22:0], 1'b0};
                if (tx_bit_q == wlen_m1) begin
                  tx_state_q <= T_GAP;
                  gap_q <= 2'h1;
                  SERIAL_TX_OE_N <= 1'b1;
                end else begin
                  tx_bit_q <= tx_bit_q + 5'h01;
                end
              end
              T_GAP: begin
                if (gap_q == `GAP_BITS) begin
                  tx_state_q <= T_IDLE;
                end else begin
                  gap_q <= gap_q + 2'h1;
                end
              end
              default: tx_state_q <= T_IDLE;
            endcase
          end
        end
      end
      if (!on_demand && (tx_state_q != T_IDLE)) begin
        tx_state_q <= T_IDLE;
      end

      // Receive side, sampling on falling edges of the chosen clock.
      re_q <= receive_enable;
      if (re_q && !receive_enable) begin
        rearm_q <= 1'b1;
      end
      if (rx_edge) begin
        if (rx_fs && (!rx_on_q || !gated_od)) begin
          // Frame sync: start or re-align on bit 0 of the first slot.
          if (rx_on_q || (receive_enable && !rearm_q)) begin
            rx_on_q <= 1'b1;
            rx_bit_q <= 5'h01;
            rx_sh_q <= rx_next;
          end
          if (receive_enable && !rx_on_q) begin
            rx_on_q <= 1'b1;
            rx_bit_q <= 5'h01;
            rx_sh_q <= rx_next;
            rearm_q <= 1'b0;
          end
        end else if (rx_on_q) begin
          rx_sh_q <= rx_next;
          if (rx_slot_done) begin
            rx_bit_q <= 5'h00;
            if (!full_q || rd_rx) begin
              rx_data_q <= rx_word;
              full_q <= 1'b1;
            end else begin
              ovr_q <= 1'b1;
            end
            if (!receive_enable || rearm_q) begin
              rx_on_q <= 1'b0;
            end
          end else begin
            rx_bit_q <= rx_bit_q + 5'h01;
          end
        end
      end

      // Registered pin and request outputs.
      RX_INT_REQ <= full_q && receive_int_enable;
      TX_INT_REQ <= tde_q && transmit_int_enable;
      BIT_CLK_OUT <= gated_od ? (bclk_q && (tx_state_q == T_SHIFT)) : bclk_q;
      FRAME_SYNC_OUT <= fs_q;
    end
  end
endmodule
`default_nettype wire

//--- design/sync_serial_defines.vh
// Constants shared by the synchronous serial port design files.
// Notes on behaviour
// - Receiver starts at first frame sync after enable.
// - Completed word moves to receive data, sets full.
// - Receive request while full and interrupt enable.
// - Next slot word shifts in without a gap.
// - Data read clears full; unread word overruns.
// - Enable toggle finishes slot, waits for frame.
// - Enables never stop bit clock or frame sync.
// - Enabled receiver captures every time slot word.
// - Network mode with zero divide is on-demand.
// - On-demand frame sync only with a word.
// - On-demand never flags a transmit underrun.
// - Two idle bit periods between on-demand words.
// - On-demand frame sync marks the word start.
// - On-demand: own transmit sync, external receive sync unless gated.
// - Transmit data write starts one pending word.
// - Empty and full work; underruns disabled on-demand.
// - Transmitter starts at first frame sync after enable.
// - Slot skip write clears empty, floats next slot.
`ifndef SYNC_SERIAL_DEFINES_VH
`define SYNC_SERIAL_DEFINES_VH
// Register addresses on the processor port.
`define ADDR_CTRL_A 16'hFFEC
`define ADDR_CTRL_B 16'hFFED
`define ADDR_STATUS 16'hFFEE
`define ADDR_DATA 16'hFFEF
`define CTRL_RESET 24'h000000
// Control A fields.
`define CA_PM_HI 7
`define CA_PM_LO 0
`define CA_DC_HI 12
`define CA_DC_LO 8
`define CA_WL_HI 14
`define CA_WL_LO 13
// Control B fields.
`define CB_RIE 15
`define CB_TIE 14
`define CB_RE 13
`define CB_TE 12
`define CB_MOD 11
`define CB_GCK 10
`define CB_SYN 9
`define CB_BIT_CLOCK_DIR 5
`define CB_FLAG0_PIN_DIR 2
// Status fields.
`define ST_RDF 7
`define ST_TDE 6
`define ST_ROE 5
`define ST_TUE 4
// Word lengths minus one, and the on-demand gap in bit periods.
`define WLEN_8 5'h07
`define WLEN_12 5'h0B
`define WLEN_16 5'h0F
`define WLEN_24 5'h17
`define GAP_BITS 2'h2
`endif

//--- design/pin_sync.v
// Two-stage synchronisers with edge detection for the serial pins.
`default_nettype none
module pin_sync (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Raw pins and synchronised views.
  input wire [3:0] pins,
  output wire [3:0] lvl,
  output wire [3:0] rise,
  output wire [3:0] fall
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      // Only the second stage looks at the first; edges come from stages two and three.
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pins[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign lvl[i] = s2_q;
      assign rise[i] = s2_q & ~s3_q;
      assign fall[i] = ~s2_q & s3_q;
    end
  endgenerate
endmodule
`default_nettype wire

//--- bench/sync_serial_port_sva.sv
// Port-level checker for the synchronous serial port.
`default_nettype none
module sync_serial_port_sva (
  // Clock, reset and register port.
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [23:0] WR_DATA,
  input wire logic [23:0] RD_DATA,
  // Outputs under watch.
  input wire logic RX_INT_REQ,
  input wire logic BIT_CLK_OUT,
  input wire logic FRAME_SYNC_OUT,
  input wire logic SERIAL_TX_OE_N
);
  logic [23:0] ca_q, cb_q;
  logic [7:0] gap_q;
  logic fs_q, pend_q, od, cont, rd_st;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////
  // Mirror control writes so the mode is known without looking inside.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ca_q <= 24'h000000;
      cb_q <= 24'h000000;
      fs_q <= 1'b0;
      pend_q <= 1'b0;
      gap_q <= 8'hFF;
    end else begin
      fs_q <= FRAME_SYNC_OUT;
      if (WR_EN && ADDR == 16'hFFEC) ca_q <= WR_DATA;
      if (WR_EN && ADDR == 16'hFFED) cb_q <= WR_DATA;
      if (WR_EN && ADDR == 16'hFFEF) pend_q <= 1'b1;
      else if (FRAME_SYNC_OUT && !fs_q) pend_q <= 1'b0;
      if (FRAME_SYNC_OUT && !fs_q) gap_q <= 8'h00;
      else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
    end
  end
  // On-demand checks judge only 8-bit, prescale-one setups, the clock check any prescale-one word length, so figures stay exact.
  assign od = cb_q[11] && ca_q[14:0] == 15'h0001;
  assign cont = cb_q[11] && !cb_q[10] && cb_q[5] && ca_q[7:0] == 8'h01;
  assign rd_st = RD_EN && ADDR == 16'hFFEE;
  property p_rdclr;
    RD_EN && ADDR == 16'hFFEF |-> ##[1:2] !RX_INT_REQ;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("request held after data read");
  property p_rie;
    $rose(RX_INT_REQ) |-> $past(cb_q[15]);
  endproperty
  a_rie: assert property (p_rie) else $error("request without enable");
  property p_fslen;
    od && $rose(FRAME_SYNC_OUT) |-> FRAME_SYNC_OUT[*4] ##1 !FRAME_SYNC_OUT;
  endproperty
  a_fslen: assert property (p_fslen) else $error("sync not one bit long");
  property p_gap;
    od && $rose(FRAME_SYNC_OUT) |-> gap_q >= 8'h27;
  endproperty
  a_gap: assert property (p_gap) else $error("words closer than two idle bits");
  property p_fsdata;
    od && $rose(FRAME_SYNC_OUT) |-> pend_q;
  endproperty
  a_fsdata: assert property (p_fsdata) else $error("sync without a written word");
  property p_oe;
    od && $rose(FRAME_SYNC_OUT) |-> ##[0:2] !SERIAL_TX_OE_N;
  endproperty
  a_oe: assert property (p_oe) else $error("line not driven at word start");
  property p_tue;
    od && rd_st |=> !RD_DATA[4];
  endproperty
  a_tue: assert property (p_tue) else $error("underrun shown on demand");
  property p_clk;
    cont && $past(cont) && $stable(BIT_CLK_OUT) |=> $changed(BIT_CLK_OUT);
  endproperty
  a_clk: assert property (p_clk) else $error("bit clock stopped");
  // The main scenarios are reached.
  c_odfs: cover property (od && $rose(FRAME_SYNC_OUT));
  c_rx: cover property ($rose(RX_INT_REQ));
  c_st: cover property (od && rd_st);
endmodule
bind sync_serial_port sync_serial_port_sva chk (.CORE_CLK, .RESET, .ADDR, .WR_EN, .RD_EN,
  .WR_DATA, .RD_DATA, .RX_INT_REQ, .BIT_CLK_OUT, .FRAME_SYNC_OUT, .SERIAL_TX_OE_N);
`default_nettype wire

//--- bench/serial_peer.sv
// Behavioural far-side peer that sends framed words to the port.
`default_nettype none
module serial_peer (
  // Receive clock, frame sync and data toward the port.
  output logic sclk,
  output logic fsync,
  output logic sdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // The clock is parked low between frames, as a gated peer does.
  initial begin
    sclk = 1'b0;
    fsync = 1'b0;
    sdata = 1'b1;
  end
  ////////////////////////////////////////
  // Sends n slots of 8 bits MSB first; a set fs marks bit 0 only.
  task automatic frame(input logic [31:0] w, input int n, input logic fs);
    int b;
    for (b = 0; b < n * 8; b++) begin
      sclk = 1'b1;
      fsync = fs && b == 0;
      sdata = w[31 - b];
      #80 sclk = 1'b0;
      #80;
    end
    fsync = 1'b0;
    sdata = ~sdata; // A released line must not keep showing its last bit.
  endtask
endmodule
`default_nettype wire

//--- bench/test_sync_serial_port.sv
// Self-checking bench for the synchronous serial port.
`default_nettype none
module test_sync_serial_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [15:0] ADDR = 16'h0000;
  logic WR_EN = 1'b0;
  logic RD_EN = 1'b0;
  logic [23:0] WR_DATA = 24'h000000;
  logic [23:0] RD_DATA, v, k;
  logic RX_INT_REQ, TX_INT_REQ, BIT_CLK_OUT, FRAME_SYNC_OUT, SERIAL_TX_OUT, SERIAL_TX_OE_N;
  logic sclk, fsync, sdata, b;
  int err_total = 0;
  int n_compared = 0;
  // The core clock runs at 50 MHz.
  always #10 CORE_CLK = ~CORE_CLK;
  sync_serial_port dut (.CORE_CLK, .RESET, .ADDR, .WR_EN, .RD_EN, .WR_DATA, .RD_DATA,
    .RX_INT_REQ, .TX_INT_REQ, .BIT_CLK_IN(1'b0), .CTL_PIN0_IN(sclk), .FRAME_SYNC_IN(fsync),
    .SERIAL_RX_PIN(sdata), .BIT_CLK_OUT, .FRAME_SYNC_OUT, .SERIAL_TX_OUT, .SERIAL_TX_OE_N);
  serial_peer peer (.sclk, .fsync, .sdata);
  ////////////////////////////////////////
  // Shared compare, bus cycles and bounded waits.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [23:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_EN <= 1'b1;
    @(posedge CORE_CLK);
    WR_EN <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [23:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge CORE_CLK);
    RD_EN <= 1'b0;
    @(negedge CORE_CLK);
    d = RD_DATA;
  endtask
  // Waits for receive request, transmit request or frame sync, never forever.
  task automatic wt(input int s);
    int i;
    logic f;
    for (i = 0; i < 4000; i++) begin
      f = (s == 0) ? RX_INT_REQ : (s == 1) ? TX_INT_REQ : FRAME_SYNC_OUT;
      if (f === 1'b1) break;
      @(negedge CORE_CLK);
    end
    if (i == 4000) begin
      chk(24'h000000, 24'h000001);
      results();
    end
  endtask
  // Samples one 8-bit word half a core cycle before each bit ends, four core cycles a bit.
  task automatic cap(input logic [23:0] e);
    logic [23:0] w;
    w = 24'h000000;
    wt(2);
    repeat (2) @(negedge CORE_CLK);
    repeat (8) begin
      w = {w[22:0], SERIAL_TX_OUT};
      repeat (4) @(negedge CORE_CLK);
    end
    chk(w, e);
  endtask
  ////////////////////////////////////////
  task automatic t_start();
    rd(16'hFFED, v);
    chk(v, 24'h000000);
    wr(16'hFFEC, 24'h000101);
    wr(16'hFFED, 24'h00A820);
    peer.frame(32'h5A000000, 1, 1'b0);
    repeat (8) @(negedge CORE_CLK);
    chk({23'h0, RX_INT_REQ}, 24'h000000);
    fork
      peer.frame(32'hC33C0000, 2, 1'b1);
      begin
        wt(0);
        rd(16'hFFEF, v);
        chk(v, 24'hC30000);
        // The request lags the flag by one cycle, so let the stale level drain first.
        repeat (2) @(negedge CORE_CLK);
        wt(0);
        rd(16'hFFEF, v);
        chk(v, 24'h3C0000);
      end
    join
    $display("start test done");
  endtask
  task automatic t_over();
    peer.frame(32'h11220000, 2, 1'b1);
    repeat (40) @(negedge CORE_CLK);
    rd(16'hFFEE, v);
    chk(v & 24'h0000A0, 24'h0000A0);
    rd(16'hFFEF, v);
    chk(v, 24'h110000);
    rd(16'hFFEE, v);
    chk(v & 24'h0000A0, 24'h000000);
    rd(16'hFFE0, v);
    chk(v, 24'h000000);
    $display("overrun test done");
  endtask
  task automatic t_toggle();
    fork
      peer.frame(32'h77660000, 2, 1'b1);
      begin
        repeat (30) @(negedge CORE_CLK);
        wr(16'hFFED, 24'h008820);
        wr(16'hFFED, 24'h00A820);
      end
    join
    repeat (8) @(negedge CORE_CLK);
    rd(16'hFFEE, v);
    chk(v & 24'h0000A0, 24'h000080);
    rd(16'hFFEF, v);
    chk(v, 24'h770000);
    $display("toggle test done");
  endtask
  task automatic t_demand();
    wr(16'hFFEC, 24'h000001);
    wr(16'hFFED, 24'h005820);
    // A periodic sync pulse may still be finishing when the mode changes.
    repeat (8) @(negedge CORE_CLK);
    k = 24'h000000;
    repeat (100) begin
      @(negedge CORE_CLK);
      k = k + {23'h0, FRAME_SYNC_OUT};
    end
    chk(k, 24'h000000);
    fork
      begin
        cap(24'h0000A5);
        cap(24'h00003C);
      end
      begin
        wt(1);
        wr(16'hFFEF, 24'hA50000);
        repeat (6) @(negedge CORE_CLK);
        wt(1);
        wr(16'hFFEF, 24'h3C0000);
      end
    join
    repeat (100) @(negedge CORE_CLK);
    rd(16'hFFEE, v);
    chk(v & 24'h000010, 24'h000000);
    wr(16'hFFED, 24'h004820);
    k = 24'h000000;
    b = BIT_CLK_OUT;
    repeat (20) begin
      @(negedge CORE_CLK);
      k = k + {23'h0, BIT_CLK_OUT != b};
      b = BIT_CLK_OUT;
    end
    chk(k, 24'h00000A);
    $display("on-demand test done");
  endtask
  // Periodic transmit: data waits for the first frame, a skip floats slot two.
  task automatic t_net();
    wr(16'hFFEC, 24'h000101);
    wt(2);
    wr(16'hFFEF, 24'h960000);
    wr(16'hFFED, 24'h001820);
    repeat (8) @(negedge CORE_CLK);
    fork
      cap(24'h000096);
      begin
        wt(2);
        wr(16'hFFEE, 24'h000000);
        repeat (40) @(negedge CORE_CLK);
        chk({23'h0, SERIAL_TX_OE_N}, 24'h000001);
      end
    join
    rd(16'hFFEE, v);
    chk(v & 24'h000050, 24'h000040);
    $display("network transmit test done");
  endtask
  // Gated on-demand with 24-bit words: the clock runs only for the word.
  task automatic t_gated();
    wr(16'hFFEC, 24'h006001);
    wr(16'hFFED, 24'h003C20);
    fork
      peer.frame(32'h69A5C300, 3, 1'b0);
      begin
        wr(16'hFFEF, 24'h5A3CC3);
        b = BIT_CLK_OUT;
        k = 24'h000000;
        repeat (110) begin
          @(negedge CORE_CLK);
          k = k + {23'h0, BIT_CLK_OUT && !b};
          b = BIT_CLK_OUT;
        end
        chk(k, 24'h000018);
      end
    join
    repeat (8) @(negedge CORE_CLK);
    rd(16'hFFEF, v);
    chk(v, 24'h69A5C3);
    $display("gated test done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset for three cycles, then run every scenario in turn.
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    t_start();
    t_over();
    t_toggle();
    t_demand();
    t_net();
    t_gated();
    results();
  end
endmodule
`default_nettype wire
